// ### rtl/vcp_pkg.sv
// Purpose: Shared constants for the voltage channel processing block.
// Assumes: aclk at 40 MHz; one converter sample per base-rate strobe.
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package vcp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] VCP_OFS_MODE   = 8'h00;  // Source and rate select.
  localparam logic [7:0] VCP_OFS_IRQEN  = 8'h04;  // Interrupt enables.
  localparam logic [7:0] VCP_OFS_STATUS = 8'h08;  // Clears on read.
  localparam logic [7:0] VCP_OFS_WAVE   = 8'h0c;  // Waveform word.
  localparam logic [7:0] VCP_OFS_RMS    = 8'h10;  // voltage_rms_result.
  localparam logic [7:0] VCP_OFS_RMSOS  = 8'h14;  // voltage_rms_offset_trim.
  localparam logic [7:0] VCP_OFS_PHASE  = 8'h18;  // phase_delay_trim.
  localparam logic [7:0] VCP_OFS_GAIN   = 8'h1c;  // Gain stage code.

  // ----------------------------------------------------------------
  // Field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned VCP_MODE_SRC_LSB  = 13;
  localparam int unsigned VCP_MODE_RATE_LSB = 11;
  localparam int unsigned VCP_WAVEFORM_SAMPLE_ENABLE_BIT      = 3;
  localparam logic [1:0]  VCP_SRC_VOLTAGE   = 2'h3;
  localparam logic [15:0] VCP_MODE_RST      = 16'h0000;
  localparam logic [5:0]  VCP_PHASE_ZERO    = 6'h0d;
  localparam logic [6:0]  VCP_PHASE_BASE    = 7'h2c;  // Taps at code zero-delay.
  localparam logic [2:0]  VCP_GAIN_MAX      = 3'h4;   // Gains 1,2,4,8,16.
  localparam logic signed [15:0] VCP_FS_POS = 16'sh2852;
  localparam logic signed [15:0] VCP_FS_NEG = 16'shd7ae;
  localparam logic [1:0]  VCP_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  VCP_RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Timing and filter constants
  // ----------------------------------------------------------------
  localparam int unsigned VCP_CLK_NS      = 25;
  localparam int unsigned VCP_SETTLE_NS   = 1230000;
  localparam int unsigned VCP_SETTLE_CYC  = (VCP_SETTLE_NS + VCP_CLK_NS - 1) / VCP_CLK_NS;
  localparam logic [2:0]  VCP_STEP_DIV_M1 = 3'h7;  // Delay step is clock/8.
  localparam logic [1:0]  VCP_RMS_DIV_M1  = 2'h3;  // Rms update is clock/4.
  localparam int unsigned VCP_LPF_SHIFT   = 5;     // About 140 Hz at 27.9 kSPS.
  localparam int unsigned VCP_RMS_SHIFT   = 20;    // Roughly 670 ms settling.
  localparam int unsigned VCP_RMS_SCALE   = 8;     // Mean |x| to result scale.

endpackage : vcp_pkg

// ### rtl/vcp_top.sv
// Purpose: Voltage channel processing: phase delay, low-pass, waveform
//          sampling, mean-absolute rms with trim, interrupt request.
// Assumes: conv_valid strobes once per base sample; inputs synchronous.
// Notes:   Registers sit behind an AXI4-Lite slave; all state is one struct.
`timescale 1ns/10ps
module vcp_top #(
  parameter int unsigned SETTLE_CYCLES = vcp_pkg::VCP_SETTLE_CYC
) (
  // Clock, reset and enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Converter sample stream
  input  wire logic [15:0] conv_sample,
  input  wire logic        conv_valid,
  // Processed outputs
  output logic [15:0]      power_sample,
  output logic [2:0]       gain_code,
  output logic [23:0]      wave_word,
  output logic             wave_valid,
  // Open-drain interrupt request, active low
  output logic             irq_n_o,
  output logic             irq_n_oe
);
  import vcp_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks and state
  // ----------------------------------------------------------------
  localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);
  localparam int unsigned AW = 24 + VCP_RMS_SHIFT;

  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("SETTLE_CYCLES must be at least one");
  end

  typedef struct packed {
    logic                  aw_ok;
    logic [7:0]            aw_addr;
    logic                  w_ok;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [15:0]           mode;
    logic [15:0]           irqen;
    logic                  ready;
    logic [23:0]           wave;
    logic                  wave_v;
    logic [23:0]           rms;
    logic [11:0]           rms_os;
    logic [5:0]            phase;
    logic [2:0]            gain;
    logic [SW-1:0]         settle;
    logic [2:0]            dec;
    logic [2:0]            step;
    logic [1:0]            quart;
    logic signed [15:0]    hold;
    logic [63:0][15:0]     dline;
    logic signed [23:0]    lpf;
    logic [AW-1:0]         acc;
  } vcp_state_s;

  vcp_state_s state_ff;
  vcp_state_s nxt_state;

  // Byte-lane merge; called with a zero base, so partial writes clear the unstrobed lanes.
  function automatic logic [31:0] vcp_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : vcp_merge

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic                     do_wr;
  logic                     do_rd;
  logic                     step_tick;
  logic                     quart_tick;
  logic [6:0]               tap;
  logic signed [15:0]       delayed;
  logic signed [15:0]       clamped;
  logic signed [23:0]       lpf_err;
  logic signed [15:0]       filt;
  logic [15:0]              mag;
  logic [23:0]              mag_sc;
  logic [2:0]               dec_mask;
  logic [1:0]               src;
  logic [1:0]               rate;
  logic signed [25:0]       trimmed;
  logic [31:0]              merged;
  logic [31:0]              rd_val;
  logic                     rd_hit;
  logic                     wr_hit;
  logic                     cfg_wr;

  always_comb begin
    nxt_state = state_ff;
    src       = state_ff.mode[VCP_MODE_SRC_LSB +: 2];
    rate      = state_ff.mode[VCP_MODE_RATE_LSB +: 2];
    do_wr     = state_ff.aw_ok && state_ff.w_ok && !state_ff.bvalid;
    do_rd     = s_axi_arvalid && !state_ff.rvalid;
    step_tick = (state_ff.step == VCP_STEP_DIV_M1);
    quart_tick = (state_ff.quart == VCP_RMS_DIV_M1);
    merged    = vcp_merge(32'h0000_0000, state_ff.w_data, state_ff.w_strb);
    wr_hit    = 1'b0;
    cfg_wr    = 1'b0;
    rd_hit    = 1'b1;
    rd_val    = 32'h0000_0000;

    // Address and data are captured independently, in either order.
    if (s_axi_awvalid && !state_ff.aw_ok) begin
      nxt_state.aw_ok   = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_ff.w_ok) begin
      nxt_state.w_ok   = 1'b1;
      nxt_state.w_data = s_axi_wdata;
      nxt_state.w_strb = s_axi_wstrb;
    end
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end

    // Prescalers for the delay steps and the rms update.
    nxt_state.step  = state_ff.step + 3'h1;
    nxt_state.quart = state_ff.quart + 2'h1;

    if (state_ff.settle != '0) begin
      nxt_state.settle = state_ff.settle - SW'(1);
    end

    if ($signed(conv_sample) > VCP_FS_POS) begin
      clamped = VCP_FS_POS;
    end else if ($signed(conv_sample) < VCP_FS_NEG) begin
      clamped = VCP_FS_NEG;
    end else begin
      clamped = $signed(conv_sample);
    end
    if (conv_valid) begin
      nxt_state.hold = clamped;
    end

    if (step_tick) begin
      nxt_state.dline = {state_ff.dline[62:0], state_ff.hold};
    end
    // zero delay at 0x0D; lower codes advance, e.g. 0x0B is
    // two taps shorter. A fixed base delay makes the advance causal.
    tap     = 7'(VCP_PHASE_BASE + 7'($signed(state_ff.phase)) - 7'(VCP_PHASE_ZERO));
    delayed = $signed(state_ff.dline[tap[5:0]]);

    lpf_err = ({{8{delayed[15]}}, delayed} <<< 8) - state_ff.lpf;
    filt    = state_ff.lpf[23:8];
    dec_mask = 3'((4'h1 << rate) - 4'h1);
    if (conv_valid) begin
      nxt_state.lpf = state_ff.lpf + (lpf_err >>> VCP_LPF_SHIFT);
      nxt_state.dec = state_ff.dec + 3'h1;
    end

    nxt_state.wave_v = 1'b0;
    if (conv_valid && ((state_ff.dec & dec_mask) == 3'h0) && (state_ff.settle == '0)) begin
      if ((src == VCP_SRC_VOLTAGE) && state_ff.irqen[VCP_WAVEFORM_SAMPLE_ENABLE_BIT]) begin
        nxt_state.wave   = {{8{filt[15]}}, filt};
        nxt_state.wave_v = 1'b1;
      end
    end

    // mean absolute value; leaky average sets settling.
    mag    = filt[15] ? 16'(-filt) : 16'(filt);
    // scale mean to result
    // Times 256 puts the mean of a full-scale 60 Hz sine near 0x17d338.
    mag_sc = 24'(mag) << VCP_RMS_SCALE;
    if (quart_tick) begin
      nxt_state.acc = state_ff.acc - (state_ff.acc >> VCP_RMS_SHIFT) + AW'(mag_sc);
    end
    trimmed = $signed({2'b00, state_ff.acc[AW-1 -: 24]})
            + 26'($signed(state_ff.rms_os));
    if (trimmed < 0) begin
      nxt_state.rms = 24'h00_0000;
    end else if (trimmed > $signed(26'h0ff_ffff)) begin
      nxt_state.rms = 24'hff_ffff;
    end else begin
      nxt_state.rms = trimmed[23:0];
    end

    // Register writes.
    if (do_wr) begin
      nxt_state.aw_ok  = 1'b0;
      nxt_state.w_ok   = 1'b0;
      nxt_state.bvalid = 1'b1;
      wr_hit = 1'b1;
      unique case (state_ff.aw_addr & 8'hfc)
        VCP_OFS_MODE: begin
          nxt_state.mode = merged[15:0];
          cfg_wr = 1'b1;
        end
        VCP_OFS_IRQEN: begin
          nxt_state.irqen = merged[15:0];
          cfg_wr = 1'b1;
        end
        VCP_OFS_RMSOS: nxt_state.rms_os = merged[11:0];
        VCP_OFS_PHASE: begin
          nxt_state.phase = merged[5:0];
          cfg_wr = 1'b1;
        end
        VCP_OFS_GAIN: begin
          nxt_state.gain = (merged[2:0] > VCP_GAIN_MAX) ? VCP_GAIN_MAX : merged[2:0];
          cfg_wr = 1'b1;
        end
        VCP_OFS_STATUS, VCP_OFS_WAVE, VCP_OFS_RMS: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      nxt_state.bresp = wr_hit ? VCP_RESP_OKAY : VCP_RESP_SLVERR;
    end
    if (cfg_wr) begin
      nxt_state.settle = SW'(SETTLE_CYCLES);
    end

    // Register reads.
    unique case (s_axi_araddr & 8'hfc)
      VCP_OFS_MODE:   rd_val = {16'h0000, state_ff.mode};
      VCP_OFS_IRQEN:  rd_val = {16'h0000, state_ff.irqen};
      VCP_OFS_STATUS: rd_val = 32'(state_ff.ready) << VCP_WAVEFORM_SAMPLE_ENABLE_BIT;
      // word right justified, top byte zero
      VCP_OFS_WAVE:   rd_val = {8'h00, state_ff.wave};
      VCP_OFS_RMS:    rd_val = {8'h00, state_ff.rms};
      VCP_OFS_RMSOS:  rd_val = {{20{state_ff.rms_os[11]}}, state_ff.rms_os};
      VCP_OFS_PHASE:  rd_val = {26'h0, state_ff.phase};
      VCP_OFS_GAIN:   rd_val = {29'h0, state_ff.gain};
      default:        rd_hit = 1'b0;
    endcase
    if (do_rd) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata  = rd_val;
      nxt_state.rresp  = rd_hit ? VCP_RESP_OKAY : VCP_RESP_SLVERR;
    end

    if (do_rd && ((s_axi_araddr & 8'hfc) == VCP_OFS_STATUS)) begin
      nxt_state.ready = 1'b0;
    end
    // new sample sets request; set wins over the read clear.
    if (nxt_state.wave_v) begin
      nxt_state.ready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset restarts settling so that no early sample is published.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff        <= '0;
      state_ff.mode   <= VCP_MODE_RST;
      state_ff.phase  <= VCP_PHASE_ZERO;
      state_ff.settle <= SW'(SETTLE_CYCLES);
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The ready outputs stay low while the clock enable freezes the slave; bvalid and rvalid hold their value.
  assign s_axi_awready = ce && !state_ff.aw_ok;
  assign s_axi_wready  = ce && !state_ff.w_ok;
  assign s_axi_arready = ce && !state_ff.rvalid;
  assign s_axi_bvalid  = state_ff.bvalid;
  assign s_axi_bresp   = state_ff.bresp;
  assign s_axi_rvalid  = state_ff.rvalid;
  assign s_axi_rdata   = state_ff.rdata;
  assign s_axi_rresp   = state_ff.rresp;

  assign power_sample = state_ff.dline[tap[5:0]];
  assign gain_code    = state_ff.gain;
  assign wave_word    = state_ff.wave;
  assign wave_valid   = state_ff.wave_v;
  // Open drain: only ever pulls low, and only while a sample waits.
  assign irq_n_o      = 1'b0;
  assign irq_n_oe     = state_ff.ready;

endmodule : vcp_top

// ### verification/vcp_top_chk.sv
// Purpose: Port-level assertions for the voltage channel block.
// Assumes: ce is held high by the bench; one clock domain.
// Notes:   Bound into vcp_top by the statement after endmodule.
`timescale 1ns/10ps
module vcp_top_chk #(
  parameter int unsigned SETTLE_CYCLES = 20
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus read side
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Sample path
  input wire logic        conv_valid,
  input wire logic [15:0] power_sample,
  input wire logic [2:0]  gain_code,
  input wire logic [23:0] wave_word,
  input wire logic        wave_valid,
  input wire logic        irq_n_o,
  input wire logic        irq_n_oe
);
  import vcp_pkg::*;
  logic [31:0] cnt_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Counts cycles since reset; config writes only lengthen settling.
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_ff <= '0;
    else if (cnt_ff != '1) cnt_ff <= cnt_ff + 32'h1;
  end
  property p_wave_sext;
    wave_valid |-> wave_word[23:16] == {8{wave_word[15]}};
  endproperty
  a_wave_sext: assert property (p_wave_sext) else $error("wave word not extended");
  property p_wave_range;
    wave_valid |-> $signed(wave_word[15:0]) <= VCP_FS_POS && $signed(wave_word[15:0]) >= VCP_FS_NEG;
  endproperty
  a_wave_range: assert property (p_wave_range) else $error("wave out of range");
  property p_power_range;
    $signed(power_sample) <= VCP_FS_POS && $signed(power_sample) >= VCP_FS_NEG;
  endproperty
  a_power_range: assert property (p_power_range) else $error("power out of range");
  property p_wave_cause;
    wave_valid |-> $past(conv_valid);
  endproperty
  a_wave_cause: assert property (p_wave_cause) else $error("wave without input");
  property p_settle;
    wave_valid |-> cnt_ff >= SETTLE_CYCLES - 1;
  endproperty
  a_settle: assert property (p_settle) else $error("wave before settling");
  property p_irq_set;
    wave_valid |-> irq_n_oe && !irq_n_o;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not driven low");
  property p_irq_clear;
    $fell(irq_n_oe) |-> $past(s_axi_arvalid && s_axi_arready &&
                              (s_axi_araddr & 8'hfc) == VCP_OFS_STATUS);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq released early");
  property p_gain_max;
    gain_code <= VCP_GAIN_MAX;
  endproperty
  a_gain_max: assert property (p_gain_max) else $error("gain code too large");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
endmodule : vcp_top_chk

bind vcp_top vcp_top_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) vcp_top_chk_inst (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .conv_valid, .power_sample, .gain_code, .wave_word,
  .wave_valid, .irq_n_o, .irq_n_oe);

// ### verification/vcp_conv_model.sv
// Purpose: Converter stream source for the voltage channel block.
// Assumes: The bench sets run and lvl; one pulse every GAP clocks.
// Notes:   Between pulses the bus shows the inverse level, so logic that
//          samples without conv_valid sees wrong data.
`timescale 1ns/10ps
module vcp_conv_model #(
  parameter int unsigned GAP = 4
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Control from the bench
  input wire logic        run,
  input wire logic [15:0] lvl,
  // Stream toward the block
  output logic [15:0]     conv_sample,
  output logic            conv_valid
);
  logic [7:0] gap_ff;
  // Free-running spacing keeps the pulse count exact in any window that is a whole number of GAP clocks long.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_ff <= 8'h00;
      conv_valid <= 1'b0;
      conv_sample <= 16'h0000;
    end else begin
      gap_ff <= (gap_ff == 8'(GAP - 1)) ? 8'h00 : gap_ff + 8'h01;
      conv_valid <= run && gap_ff == 8'h00;
      conv_sample <= (gap_ff == 8'h00) ? lvl : ~lvl;
    end
  end
endmodule : vcp_conv_model

// ### verification/vcp_top_tb_top.sv
// Purpose: Self-checking bench for the voltage channel block.
// Assumes: Settling shortened to 20 cycles; ce held high throughout.
// Notes:   Expected values follow from the package constants.
`timescale 1ns/10ps
module vcp_top_tb_top;
  import vcp_pkg::*;
  logic        aclk, aresetn, run, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, conv_valid, wave_valid, irq_n_o, irq_n_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  gain_code;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] conv_sample, power_sample, lvl;
  logic [23:0] wave_word;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          error_cnt, samples_checked, wave_cnt, w0, d0, d1;
  vcp_top #(.SETTLE_CYCLES(20)) vcp_top_inst (.aclk, .aresetn, .ce(1'b1), .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .conv_sample, .conv_valid,
    .power_sample, .gain_code, .wave_word, .wave_valid, .irq_n_o, .irq_n_oe);
  vcp_conv_model #(.GAP(4)) vcp_conv_model_inst (.aclk, .aresetn, .run, .lvl, .conv_sample,
    .conv_valid);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (wave_valid === 1'b1) wave_cnt <= wave_cnt + 1;
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // A bus that never answers ends the run instead of hanging it.
  task automatic tmo(input int n);
    if (n >= 200) begin
      error_cnt++;
      close_out();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    tmo(n);
    // Let an edge pass so the next call never re-raises bready in this step.
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re = 2'h0);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk({30'h0, s_axi_rresp}, {30'h0, re});
    if (re === VCP_RESP_OKAY) chk(s_axi_rdata, e);
    // Let an edge pass so the next call never re-raises rready in this step.
    @(posedge aclk);
  endtask : rd
  // Sends sixteen input pulses after settling and counts waveform pulses.
  task automatic sweep(input int e);
    repeat (40) @(posedge aclk);
    w0 = wave_cnt;
    run <= 1'b1;
    repeat (64) @(posedge aclk);
    run <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(32'(wave_cnt - w0), 32'(e));
  endtask : sweep
  // Cycles from a step at the input to the step at the power tap.
  task automatic pdel(input logic [5:0] c, output int d);
    wr(VCP_OFS_PHASE, {26'h0, c});
    lvl <= 16'h8000;
    repeat (600) @(posedge aclk);
    chk({16'h0, power_sample}, {16'h0, VCP_FS_NEG});
    lvl <= 16'h7fff;
    d = 0;
    while (power_sample !== VCP_FS_POS && d < 1000) begin
      @(posedge aclk);
      d++;
    end
    chk({31'h0, wave_word == {8'h00, VCP_FS_POS}}, 32'h0);
  endtask : pdel
  initial begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {lvl, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(VCP_OFS_PHASE, 32'h0d);
    rd(VCP_OFS_RMS, 32'h0);
    rd(VCP_OFS_WAVE, 32'h0);
    rd(8'h20, 32'h0, VCP_RESP_SLVERR);
    wr(8'h24, 32'h1);
    chk({30'h0, rsp}, {30'h0, VCP_RESP_SLVERR});
    wr(VCP_OFS_RMS, 32'hffffffff);
    rd(VCP_OFS_RMS, 32'h0);
    // With no input the estimate is zero, so the trim shows unscaled.
    wr(VCP_OFS_RMSOS, 32'h7ff);
    repeat (20) @(posedge aclk);
    rd(VCP_OFS_RMS, 32'h7ff);
    wr(VCP_OFS_RMSOS, 32'hfffff800);
    repeat (20) @(posedge aclk);
    // The trim is signed, so it reads back sign extended.
    rd(VCP_OFS_RMSOS, 32'hfffff800);
    rd(VCP_OFS_RMS, 32'h0);
    wr(VCP_OFS_RMSOS, 32'h0);
    wr(VCP_OFS_PHASE, 32'hffffffff);
    rd(VCP_OFS_PHASE, 32'h3f);
    for (int g = 0; g < 8; g++) begin
      wr(VCP_OFS_GAIN, 32'(g));
      repeat (2) @(posedge aclk);
      chk({29'h0, gain_code}, 32'((g > 4) ? 4 : g));
    end
    // Only source code 11 together with the enable passes samples.
    lvl <= 16'h8000;
    wr(VCP_OFS_IRQEN, 32'h8);
    wr(VCP_OFS_MODE, 32'h2000);
    sweep(0);
    wr(VCP_OFS_IRQEN, 32'h0);
    wr(VCP_OFS_MODE, 32'h6000);
    sweep(0);
    wr(VCP_OFS_IRQEN, 32'h8);
    for (int r = 0; r < 4; r++) begin
      wr(VCP_OFS_MODE, 32'(32'h6000 | (r << 11)));
      sweep(16 >> r);
    end
    rd(VCP_OFS_MODE, 32'h7800);
    chk({24'h0, wave_word[23:16]}, 32'hff);
    chk({31'h0, wave_word == 24'hffd7ae}, 32'h0);
    chk({31'h0, irq_n_oe}, 32'h1);
    rd(VCP_OFS_STATUS, 32'h8);
    @(posedge aclk);
    chk({31'h0, irq_n_oe}, 32'h0);
    rd(VCP_OFS_STATUS, 32'h0);
    // Two steps of advance shorten the path by about sixteen clocks.
    run <= 1'b1;
    pdel(VCP_PHASE_ZERO, d0);
    pdel(6'h0b, d1);
    chk({31'h0, (d0 - d1) inside {[4:28]} && d0 < 1000}, 32'h1);
    run <= 1'b0;
    close_out();
  end
endmodule : vcp_top_tb_top
